/* File: include/hsp_pkg.sv */
/*
  Package for the host-side controller of a byte-wide asynchronous static
  memory with a hardware-triggered nonvolatile save line.
  Assumes a single 50 MHz clock; all pin timing is counted in its cycles.
*/
package hsp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W        = 15;
  localparam int DATA_W        = 8;

  // slowest grade bus timing, in ns, us or ms as each name ends
  localparam int T_CYCLE_NS    = 45;
  localparam int T_WRITE_NS    = 30;
  localparam int T_ACCESS_NS   = 45;
  localparam int T_HIZ_NS      = 15;
  localparam int T_SAVE_PULSE_NS = 15;
  localparam int T_BUSY_NS     = 300;
  localparam int T_COMPL_US    = 1;
  localparam int T_SAVE_MS     = 10;
  localparam int T_RECOVER_NS  = 700;

  function automatic int ceil_cyc(input int ns);
    ceil_cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ceil_cyc < 1) ceil_cyc = 1;
  endfunction

  localparam int CYC_WRITE   = ceil_cyc(T_WRITE_NS);
  localparam int CYC_ACCESS  = ceil_cyc(T_ACCESS_NS) + 1;
  localparam int CYC_HIZ     = ceil_cyc(T_HIZ_NS);
  localparam int CYC_PULSE   = ceil_cyc(T_SAVE_PULSE_NS);
  localparam int CYC_BUSY    = ceil_cyc(T_BUSY_NS);
  localparam int CYC_COMPL   = ceil_cyc(T_COMPL_US * 1000);
  localparam int CYC_SAVE    = ceil_cyc(T_SAVE_MS * 1000000);
  localparam int CYC_RECOVER = ceil_cyc(T_RECOVER_NS);

  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SAVE  = 2'h2;

  typedef struct packed {
    logic [1:0]        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hsp_req_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_PULSE = 3'h3,
    ST_END   = 3'h2,
    ST_SAVE  = 3'h6,
    ST_WAIT  = 3'h7,
    ST_REC   = 3'h5
  } hsp_state_e;
endpackage

/* File: logic/hsp_ctrl.sv */
/*
  Host controller for an asynchronous byte memory with a save request line.
  Assumes the user issues one request at a time on REQ_VALID/REQ_READY and
  that the memory's busy drive on the store line is open-drain.
*/
// Notes on behaviour
// (R1) read: select low, strobe and store high
// (R2) write: select and strobe low, store high
// (R3) device releases bus after deselect
// (R4) strobe low at select: outputs stay off
// (R5) strobe fall turns device outputs off
// (R6) address changes only while deselected
// (R7) select held low long enough for write
// (R8) store low forces save, only if dirty
// (R9) store request pulse at least 15 ns
// (R10) busy within 300 ns, save under 10 ms
// (R11) in-flight cycle gets 1 us to finish
// (R12) after save, device blocks until release
// (R13) access resumes within 700 ns of release
// (R14) recovery counts only after save elapses
// (R15) no access during nonvolatile transfer
// (R16) dirty flag set by writes, cleared by save
// (R17) output enable high during writes
`timescale 1ns/10ps
module hsp_ctrl
  import hsp_pkg::*;
#(
  parameter int SAVE_CYCLES = CYC_SAVE
) (
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire hsp_req_s          REQ,
  input  wire logic              REQ_VALID,
  output      logic              REQ_READY,
  output      logic [DATA_W-1:0] RDATA,
  output      logic              RDATA_VALID,
  output      logic              SAVE_DONE,
  output      logic              DIRTY,
  output      logic              CS_N,
  output      logic              WE_N,
  output      logic              OE_N,
  output      logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] DQ_I,
  output      logic [DATA_W-1:0] DQ_O,
  output      logic              DQ_OE_N,
  input  wire logic              STORE_REQ_N_I,
  output      logic              STORE_REQ_N_O,
  output      logic              STORE_REQ_N_OE_N
);
  // a zero count would wrap the down counter to all ones, a save two to four times the longest count
  if (SAVE_CYCLES < 1) begin : g_bad_save
    $error("SAVE_CYCLES must be at least one");
  end

  // the counter also carries the completion window, so size it for both
  localparam int CNT_MAX = (SAVE_CYCLES > CYC_COMPL + CYC_BUSY)
                           ? SAVE_CYCLES : CYC_COMPL + CYC_BUSY;
  localparam int CW      = $clog2(CNT_MAX + 1) + 1;

  hsp_state_e            state_r;
  logic [CW-1:0]         cnt_r;
  logic [1:0]            op_r;
  logic [DATA_W-1:0]     dq_meta_r, dq_sync_r;
  logic [1:0]            busy_sync_r;
  logic                  dirty_r;
  logic                  read_cap;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n - 1);
  endfunction

  assign REQ_READY = (state_r == ST_IDLE);
  assign DIRTY     = dirty_r;
  assign STORE_REQ_N_O = 1'b0;
  assign read_cap  = (state_r == ST_END) && (op_r == OP_READ)
                     && (cnt_r == '0);

  // pin inputs pass two flip-flops before any use
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dq_meta_r   <= '0;
      dq_sync_r   <= '0;
      busy_sync_r <= 2'h3;
    end else begin
      dq_meta_r   <= DQ_I;
      dq_sync_r   <= dq_meta_r;
      busy_sync_r <= {busy_sync_r[0], STORE_REQ_N_I};
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      op_r    <= OP_READ;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (REQ_VALID) begin
            op_r  <= REQ.op;
            if (REQ.op == OP_SAVE) begin
              state_r <= ST_SAVE;
              cnt_r   <= cyc(CYC_COMPL + CYC_BUSY); // R9 R11
            end else begin
              state_r <= ST_SETUP;
              cnt_r   <= '0;
            end
          end
        end
        // address settles one cycle before select falls
        ST_SETUP: begin
          state_r <= ST_PULSE;
          cnt_r   <= (op_r == OP_WRITE) ? cyc(CYC_WRITE)     // R7
                                        : cyc(CYC_ACCESS);
        end
        ST_PULSE: begin
          if (cnt_r == '0) begin
            state_r <= ST_END;
            // two extra cycles cover the data synchroniser
            cnt_r   <= (op_r == OP_READ) ? CW'(2) : cyc(CYC_HIZ);
          end else
            cnt_r <= cnt_r - 1'b1;
        end
        ST_END: begin
          if (cnt_r == '0) begin
            state_r <= ST_IDLE;
          end else
            cnt_r <= cnt_r - 1'b1;
        end
        // hold request through the completion window, then the save time
        ST_SAVE: begin
          if (cnt_r == '0) begin
            state_r <= ST_WAIT;
            cnt_r   <= cyc(SAVE_CYCLES); // R10 R14
          end else
            cnt_r <= cnt_r - 1'b1;
        end
        ST_WAIT: begin
          if (cnt_r == '0) begin
            state_r <= ST_REC; // R12
            cnt_r   <= cyc(CYC_RECOVER); // R13
          end else
            cnt_r <= cnt_r - 1'b1;
        end
        // wait out recovery and any device busy drive on the line
        ST_REC: begin
          if (cnt_r == '0) begin
            if (busy_sync_r[1]) state_r <= ST_IDLE; // R15
          end else
            cnt_r <= cnt_r - 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // pin drive: one flop per pin so outputs change glitch free
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CS_N <= 1'b1;
      WE_N <= 1'b1;
      OE_N <= 1'b1;
      ADDR <= '0;
      DQ_O <= '0;
      DQ_OE_N <= 1'b1;
      STORE_REQ_N_OE_N <= 1'b1;
    end else begin
      if (state_r == ST_IDLE && REQ_VALID && REQ.op != OP_SAVE) begin
        ADDR <= REQ.addr; // R6
        DQ_O <= REQ.wdata;
      end
      CS_N <= !(state_r == ST_SETUP || state_r == ST_PULSE);
      WE_N <= !((state_r == ST_SETUP || state_r == ST_PULSE)
                && op_r == OP_WRITE && !(state_r == ST_PULSE
                && cnt_r == '0)); // R2 R4
      OE_N <= !((state_r == ST_SETUP || state_r == ST_PULSE)
                && op_r == OP_READ); // R1 R17
      DQ_OE_N <= !((state_r == ST_SETUP || state_r == ST_PULSE)
                   && op_r == OP_WRITE); // R5
      STORE_REQ_N_OE_N <= !(state_r == ST_SAVE || state_r == ST_WAIT
                            || (state_r == ST_IDLE && REQ_VALID
                                && REQ.op == OP_SAVE)); // R8
    end
  end

  // the host mirrors the device's dirty state to tell whether saves run
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      dirty_r <= 1'b0;
    else if (state_r == ST_END && op_r == OP_WRITE && cnt_r == '0)
      dirty_r <= 1'b1; // R16
    else if (state_r == ST_WAIT && cnt_r == '0)
      dirty_r <= 1'b0; // R16
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA       <= '0;
      RDATA_VALID <= 1'b0;
      SAVE_DONE   <= 1'b0;
    end else begin
      RDATA_VALID <= read_cap;
      if (read_cap) RDATA <= dq_sync_r; // R3
      SAVE_DONE   <= (state_r == ST_REC) && (cnt_r == '0)
                     && busy_sync_r[1];
    end
  end

  a_write_no_oe: assert property (@(posedge CLOCK) disable iff (RST)
    !WE_N |-> OE_N) else $error("output enable low during write"); // R17
  a_save_stable: assert property (@(posedge CLOCK) disable iff (RST)
    !STORE_REQ_N_OE_N |-> CS_N) else $error("select during save"); // R1
  a_addr_stable: assert property (@(posedge CLOCK) disable iff (RST)
    !CS_N && !WE_N |=> $stable(ADDR)) else $error("address moved"); // R6
  a_we_in_cs: assert property (@(posedge CLOCK) disable iff (RST)
    !WE_N |-> !CS_N) else $error("strobe outside select"); // R2
  sequence s_wr_start;
    $fell(CS_N) && !WE_N;
  endsequence
  a_write_width: assert property (@(posedge CLOCK) disable iff (RST)
    s_wr_start |-> !CS_N [*2]) else $error("write too short"); // R7
  a_pulse_width: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(STORE_REQ_N_OE_N) |=> !STORE_REQ_N_OE_N)
    else $error("save pulse too short"); // R9
  a_no_access: assert property (@(posedge CLOCK) disable iff (RST)
    state_r == ST_REC |-> CS_N) else $error("access in recovery"); // R12
  a_dirty_set: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(WE_N) && !DQ_OE_N |-> ##[1:3] dirty_r)
    else $error("dirty not set"); // R16
endmodule

/* File: verification/hsp_mem_model.sv */
/*
  Behavioural byte memory with an open-drain save line, seen from the pins.
  Assumes the bench resolves the store line and the shared data bus.
*/
`timescale 1ns/10ps
module hsp_mem_model #(
  parameter int SAVE_NS = 500,
  parameter int REC_NS  = 300
) (
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  dq_in,
  input  wire logic        store_n,
  output      logic [7:0]  dq_out,
  output      logic        busy_oe_n
);
  logic [7:0] mem [0:32767];
  logic       wr_arm = 1'b0;
  logic       dirty = 1'b0;
  logic       inhib = 1'b0;
  logic [7:0] pat   = 8'h5a;
  wire        wr_on = !cs_n && !we_n && store_n && !inhib;
  wire        rd_on = !cs_n && we_n && !oe_n && store_n && !inhib;
  initial busy_oe_n = 1'b1;
  // a released bus keeps changing so a stale byte never passes for data
  always #10 pat = ~{pat[6:0], pat[7]};
  always @* dq_out = rd_on ? mem[addr] : pat;
  // strobes leave unknown at reset; only a write seen open may commit
  always @(posedge wr_on) wr_arm = (wr_on === 1'b1);
  always @(negedge wr_on) if (wr_arm) begin
    mem[addr] = dq_in;
    dirty = 1'b1;
    wr_arm = 1'b0;
  end
  always @(negedge store_n) if (busy_oe_n) begin
    // a write open at the fall has already committed through wr_on
    inhib = 1'b1;
    if (dirty) begin
      #100 busy_oe_n = 1'b0;
      #(SAVE_NS) dirty = 1'b0;
      busy_oe_n = 1'b1;
    end
    wait (store_n);
    #(REC_NS) inhib = 1'b0;
  end
endmodule

/* File: verification/async_sram_hw_store_port_tb_top.sv */
/*
  Self-checking bench: random writes, read-back, saves clean and dirty.
  Assumes hsp_ctrl with a short save count and the memory model beside it.
*/
`timescale 1ns/10ps
module async_sram_hw_store_port_tb_top;
  import hsp_pkg::*;
  logic CLOCK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, saw_busy = 1'b0;
  hsp_req_s REQ = '0;
  logic [DATA_W-1:0] RDATA, DQ_O, dq_dev, dq_bus, sh_d [16];
  logic [ADDR_W-1:0] ADDR, sh_a [16], prev_a;
  logic REQ_READY, RDATA_VALID, SAVE_DONE, DIRTY, CS_N, WE_N, OE_N, DQ_OE_N;
  logic [31:0] r;
  logic STORE_REQ_N_O, STORE_REQ_N_OE_N, busy_oe_n, prev_w;
  logic [31:0] seed = 32'h0000ec16;
  int num_errors = 0, n_tests = 0;
  wire store_n = (STORE_REQ_N_OE_N | STORE_REQ_N_O) & busy_oe_n;
  assign dq_bus = DQ_OE_N ? dq_dev : DQ_O;
  always #10 CLOCK = ~CLOCK;
  always @(negedge busy_oe_n) saw_busy = 1'b1;
  hsp_ctrl #(.SAVE_CYCLES(40)) dut_u (.CLOCK(CLOCK), .RST(RST), .REQ(REQ),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RDATA(RDATA),
    .RDATA_VALID(RDATA_VALID), .SAVE_DONE(SAVE_DONE), .DIRTY(DIRTY),
    .CS_N(CS_N), .WE_N(WE_N), .OE_N(OE_N), .ADDR(ADDR), .DQ_I(dq_bus),
    .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .STORE_REQ_N_I(store_n),
    .STORE_REQ_N_O(STORE_REQ_N_O), .STORE_REQ_N_OE_N(STORE_REQ_N_OE_N));
  hsp_mem_model mem_u (.cs_n(CS_N), .we_n(WE_N), .oe_n(OE_N), .addr(ADDR),
    .dq_in(dq_bus), .store_n(store_n), .dq_out(dq_dev),
    .busy_oe_n(busy_oe_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d of %0d compares", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = REQ_READY;
      1: pick = RDATA_VALID;
      default: pick = SAVE_DONE;
    endcase
  endfunction
  task automatic tick_until(input int w, input int lim);
    int n;
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    if (pick(w) !== 1'b1) begin
      check(0, 1);
      results();
    end
  endtask
  task automatic issue(input logic [1:0] op, input logic [14:0] a,
                       input logic [7:0] d);
    tick_until(0, 400);
    REQ = '{op: op, addr: a, wdata: d};
    REQ_VALID = 1'b1;
    @(posedge CLOCK);
    #1;
    REQ_VALID = 1'b0;
  endtask
  task automatic read_chk(input int i);
    issue(OP_READ, sh_a[i], 8'h00);
    @(posedge CLOCK);
    #1;
    tick_until(1, 20);
    check(RDATA, sh_d[i]);
  endtask
  task automatic save_chk(input logic exp_busy);
    saw_busy = 1'b0;
    issue(OP_SAVE, 15'h0000, 8'h00);
    tick_until(2, 400);
    check(saw_busy, exp_busy);
    check(DIRTY, 1'b0);
  endtask
  // host-side bus discipline seen at the pins on every rising clock edge out of reset
  always @(posedge CLOCK) if (!RST) begin
    if (!CS_N) check(store_n, 1'b1);
    if (!WE_N) check(OE_N, 1'b1);
    if (!CS_N && !WE_N && prev_w) check(ADDR, prev_a);
    prev_w = !CS_N && !WE_N;
    prev_a = ADDR;
  end
  initial begin
    repeat (8) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    check(DIRTY, 1'b0);
    save_chk(1'b0);
    for (int i = 0; i < 16; i++) begin
      // low nibble carries the index so no two addresses can collide
      r = rnd();
      sh_a[i] = (i == 0) ? 15'h0000 : (i == 15) ? 15'h7fff
                                    : {r[10:0], i[3:0]};
      r = rnd();
      sh_d[i] = r[7:0];
      issue(OP_WRITE, sh_a[i], sh_d[i]);
    end
    tick_until(0, 20);
    check(DIRTY, 1'b1);
    for (int i = 15; i >= 0; i--) read_chk(i);
    save_chk(1'b1);
    for (int i = 0; i < 16; i++) read_chk(i);
    sh_d[3] = ~sh_d[3];
    issue(OP_WRITE, sh_a[3], sh_d[3]);
    read_chk(3);
    results();
  end
endmodule
